// ==== core/ssv_top.sv ====
// supply supervisor: power on/off, regulator monitors, can gating, ahb-lite regs
//
// What this block does
// - battery below off threshold forces Off now
// - Off exits to Standby above on threshold
// - leaving Off sets the power-on flag
// - dissipation bit picks 85 mA or 50 mA
// - main undervoltage at the chosen level triggers system reset
// - reset level bit picks 90 % or 70 %
// - main warning flag at 90 % always
// - main status bit readable in status
// - mode field switches xcvr regulator; 10 off
// - xcvr warning flag below 90 % in Normal
// - xcvr status real only in Normal
// - monitoring works with external xcvr supply
// - can active only in Normal mode
// - can active needs standby bit zero
// - can active needs xcvr pin supply good
// - active: rx shown, controller drives tx
// - Standby/Sleep with standby bit zero: off
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "ssv_defines.svh"

module ssv_top
  import ssv_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // analog comparators, asynchronous
  input  wire logic        bat_below_poff,
  input  wire logic        bat_above_pon,
  input  wire logic        main_uv90,
  input  wire logic        main_uv70,
  input  wire logic        xcvr_uv90,
  input  wire logic        xcvr_pin_uv,
  // can path
  input  wire logic        can_bus_rx,
  input  wire logic        can_transmit_in,
  output logic             can_receive_out,
  output logic             can_tx_drive,
  output logic             can_active,
  output logic             can_off,
  // regulator and reset control
  output logic             main_reg_enable,
  output logic             xcvr_reg_enable,
  output logic             system_reset,
  output logic             ext_transistor_drive_lo
);

  // ========================================================
  // state record
  ssv_state_type q;         // registered state
  ssv_state_type d;         // next state

  logic          addr_ph;   // address phase accepted
  logic          on_q;      // chip powered
  logic          normal_q;  // chip in Normal mode
  logic          bat_low;   // synced off detect
  logic          bat_ok;    // synced on detect
  logic          muv90;     // synced main 90 % detect
  logic          muv70;     // synced main 70 % detect
  logic          xuv90;     // synced xcvr 90 % detect
  logic          xpin;      // synced xcvr pin undervoltage

  // only nonseq and seq carry a transfer
  assign addr_ph  = hsel & hready & htrans[1];
  assign on_q     = (q.pwr == SSV_PWR_ON);
  // normal mode is 10 or 11, the upper bit alone
  assign normal_q = on_q & q.mode[1];
  // logic reads only the second stage
  assign bat_low  = q.s2[`SSV_IN_POFF];
  assign bat_ok   = q.s2[`SSV_IN_PON];
  assign muv90    = q.s2[`SSV_IN_MUV90];
  assign muv70    = q.s2[`SSV_IN_MUV70];
  assign xuv90    = q.s2[`SSV_IN_XUV90];
  assign xpin     = q.s2[`SSV_IN_XPIN];

  // ========================================================
  // next state
  always_comb
  begin
    d = q;
    // two-stage synchroniser on every comparator and can pin
    d.s1 = {can_transmit_in, can_bus_rx, xcvr_pin_uv, xcvr_uv90,
            main_uv70, main_uv90, bat_above_pon, bat_below_poff};
    d.s2 = q.s1;
    d.muv_prev = muv90;
    d.xuv_prev = xuv90;

    // power state; off detect has priority
    unique case (q.pwr)
      SSV_PWR_OFF:
      begin
        // exit only when off detect has gone
        if (bat_ok && !bat_low)
        begin
          d.pwr = SSV_PWR_ON;
        end
      end
      SSV_PWR_ON:
      begin
        if (bat_low)
        begin
          d.pwr = SSV_PWR_OFF;
        end
      end
    endcase

    // bus: zero wait, always okay
    d.hready  = 1'b1;
    d.wr_pend = 1'b0;
    if (addr_ph && hwrite)
    begin
      d.wr_pend = 1'b1;
      d.wr_addr = haddr[7:0];
    end

    // read data prepared in the address phase
    if (addr_ph && !hwrite)
    begin
      d.hrdata = 32'h0000_0000;
      unique case (haddr[7:0])
        `SSV_MODE_OFS:
        begin
          d.hrdata[`SSV_MODE_MSB:`SSV_MODE_LSB] = q.mode;
          d.hrdata[`SSV_DSEL_BIT] = q.dsel;
        end
        `SSV_CTRL_OFS:
        begin
          d.hrdata[`SSV_RSEL_BIT] = q.rsel;
          d.hrdata[`SSV_STB_BIT]  = q.stb;
        end
        `SSV_IRQ_OFS:
        begin
          d.hrdata[2:0] = q.irq;
        end
        `SSV_STAT_OFS:
        begin
          d.hrdata[`SSV_ST_MAIN] = q.main_st;
          d.hrdata[`SSV_ST_XCVR] = q.xcvr_st;
          d.hrdata[`SSV_ST_PWR]  = on_q;
        end
        // unmapped offsets read zero
        default:
        begin
          d.hrdata = 32'h0000_0000;
        end
      endcase
    end

    // write data phase; logic is dead while off
    if (q.wr_pend && on_q)
    begin
      unique case (q.wr_addr)
        `SSV_MODE_OFS:
        begin
          d.mode = hwdata[`SSV_MODE_MSB:`SSV_MODE_LSB];
          d.dsel = hwdata[`SSV_DSEL_BIT];
        end
        `SSV_CTRL_OFS:
        begin
          d.rsel = hwdata[`SSV_RSEL_BIT];
          d.stb  = hwdata[`SSV_STB_BIT];
        end
        `SSV_IRQ_OFS:
        begin
          // write one to clear
          d.irq = q.irq & ~hwdata[2:0];
        end
        // status and unmapped ignore writes
        default:
        begin
          d.irq = d.irq;
        end
      endcase
    end

    // flag sets come after the clear so a set wins
    if (muv90 && !q.muv_prev && on_q)
    begin
      // warning independent of reset level
      d.irq[`SSV_IRQ_MUV] = 1'b1;
    end
    // xcvr watched in Normal, internal or external feed
    if (xuv90 && !q.xuv_prev && normal_q)
    begin
      d.irq[`SSV_IRQ_XUV] = 1'b1;
    end

    // internal logic is shut down while off
    if (!on_q)
    begin
      d.mode = `SSV_MODE_RST;
      d.dsel = 1'b0;
      d.rsel = 1'b0;
      d.stb  = 1'b0;
      d.irq  = `SSV_IRQ_RST;
      // leaving off: standby mode, power-on flag raised
      if (d.pwr == SSV_PWR_ON)
      begin
        d.irq[`SSV_IRQ_PON] = 1'b1;
      end
    end

    // outputs, all from registered state
    d.main_en = on_q;
    // mode 11 powers the regulator, 10 leaves it for an external feed
    d.xcvr_en = on_q && (q.mode == `SSV_MC_NORM_INT);
    // reset at the chosen level; held while off
    d.sys_rst = !on_q || (q.rsel ? muv70 : muv90);
    d.thr_lo  = q.dsel;
    d.main_st = !muv90;
    // real xcvr condition only in Normal, else one
    d.xcvr_st = normal_q ? !xuv90 : 1'b1;
    // pin check covers both feeds of the xcvr supply
    d.can_act = normal_q && !q.stb && !xpin;
    d.can_off = !on_q || (!q.mode[1] && !q.stb);
    // recessive high whenever not active
    d.rx_out  = q.can_act ? q.s2[`SSV_IN_RX] : 1'b1;
    d.tx_drv  = q.can_act ? q.s2[`SSV_IN_TX] : 1'b1;
  end

  // ========================================================
  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // chip starts in off until battery is good
      q         <= '0;
      q.pwr     <= SSV_PWR_OFF;
      q.s1      <= `SSV_SYNC_RST;
      q.s2      <= `SSV_SYNC_RST;
      q.muv_prev <= 1'b1;
      q.xuv_prev <= 1'b1;
      q.sys_rst <= 1'b1;
      q.can_off <= 1'b1;
      q.rx_out  <= 1'b1;
      q.tx_drv  <= 1'b1;
      q.xcvr_st <= 1'b1;
      q.hready  <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ========================================================
  // outputs straight from flops; hresp tied to zero
  assign hreadyout               = q.hready;
  assign hresp                   = 1'b0;
  assign hrdata                  = q.hrdata;
  assign can_receive_out         = q.rx_out;
  assign can_tx_drive            = q.tx_drv;
  assign can_active              = q.can_act;
  assign can_off                 = q.can_off;
  assign main_reg_enable         = q.main_en;
  assign xcvr_reg_enable         = q.xcvr_en;
  assign system_reset            = q.sys_rst;
  assign ext_transistor_drive_lo = q.thr_lo;

  // ========================================================
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  off_entry_a: assert property (bat_low |=> !on_q)
    else $error("off detect did not force off");

  off_shut_a: assert property (!on_q |=> !main_reg_enable && system_reset)
    else $error("regulator or reset wrong while off");

  leave_off_a: assert property (!on_q && bat_ok && !bat_low |=> on_q)
    else $error("off not left on power-on detect");

  pon_flag_a: assert property ($rose(on_q) |-> q.irq[`SSV_IRQ_PON])
    else $error("power-on flag not set on exit");

  thr_sel_a: assert property (##1 ext_transistor_drive_lo == $past(q.dsel))
    else $error("threshold select not following bit");

  reset_lvl_a: assert property (on_q && (q.rsel ? muv70 : muv90)
    |=> system_reset)
    else $error("undervoltage did not reset");

  no_reset_a: assert property (on_q && !muv90 && !muv70 |=> !system_reset)
    else $error("reset without undervoltage");

  main_warn_a: assert property (on_q && $rose(muv90) ##1 on_q
    |-> q.irq[`SSV_IRQ_MUV])
    else $error("main warning lost");

  xcvr_stat_a: assert property (!normal_q |=> q.xcvr_st)
    else $error("xcvr status not one outside normal");

  xcvr_reg_a: assert property (##1 xcvr_reg_enable
    == $past(on_q && q.mode == `SSV_MC_NORM_INT))
    else $error("xcvr regulator enable wrong");

  can_gate_a: assert property (##1 can_active
    == $past(normal_q && !q.stb && !xpin))
    else $error("can active gating wrong");

  can_path_a: assert property (!can_active |=> can_receive_out
    && can_tx_drive)
    else $error("can path not recessive when idle");

  can_off_a: assert property (on_q && !q.mode[1] && !q.stb |=> can_off)
    else $error("can not off in standby");

  // registers fall back to standby while the chip is off
  off_regs_a: assert property (!on_q |=> q.mode == `SSV_MC_STANDBY)
    else $error("mode kept while off");

  main_stat_a: assert property (on_q && muv90 |=> !q.main_st)
    else $error("main status good during undervoltage");

  // the xcvr warning must also fire with an external feed
  xcvr_warn_a: assert property (normal_q && $rose(xuv90) |=> q.irq[`SSV_IRQ_XUV])
    else $error("xcvr warning lost");

  xcvr_off_a: assert property (!normal_q |=> !xcvr_reg_enable)
    else $error("xcvr regulator on outside normal");

  can_idle_a: assert property (!normal_q |=> !can_active)
    else $error("can active outside normal");

  // power-on flag cannot be set while on, so a clear must stick
  pon_clear_a: assert property (on_q && q.wr_pend && q.wr_addr == `SSV_IRQ_OFS
    && hwdata[`SSV_IRQ_PON] |=> !q.irq[`SSV_IRQ_PON])
    else $error("power-on flag not cleared");

endmodule : ssv_top

// ==== core/ssv_defines.svh ====
// offsets, field positions, reset values and input indices of the supply supervisor
`ifndef SSV_DEFINES_SVH
`define SSV_DEFINES_SVH
// ==========================================================
// register byte offsets
`define SSV_MODE_OFS     8'h00
`define SSV_CTRL_OFS     8'h04
`define SSV_IRQ_OFS      8'h08
`define SSV_STAT_OFS     8'h0C
// ==========================================================
// mode register fields
`define SSV_MODE_MSB     1
`define SSV_MODE_LSB     0
`define SSV_DSEL_BIT     2
// control register fields
`define SSV_RSEL_BIT     0
`define SSV_STB_BIT      1
// interrupt status fields
`define SSV_IRQ_PON      0
`define SSV_IRQ_MUV      1
`define SSV_IRQ_XUV      2
// status register fields
`define SSV_ST_MAIN      0
`define SSV_ST_XCVR      1
`define SSV_ST_PWR       2
// ==========================================================
// reset values
`define SSV_MODE_RST     2'h0
`define SSV_IRQ_RST      3'h0
// synchroniser reset: undervoltage detects read as present so no false edge follows reset
`define SSV_SYNC_RST     8'h3C
// chip mode codes
`define SSV_MC_STANDBY   2'h0
`define SSV_MC_SLEEP     2'h1
`define SSV_MC_NORM_EXT  2'h2
`define SSV_MC_NORM_INT  2'h3
// ==========================================================
// synchroniser input positions
`define SSV_NSYNC        8
`define SSV_IN_POFF      0
`define SSV_IN_PON       1
`define SSV_IN_MUV90     2
`define SSV_IN_MUV70     3
`define SSV_IN_XUV90     4
`define SSV_IN_XPIN      5
`define SSV_IN_RX        6
`define SSV_IN_TX        7
`endif

// ==== core/ssv_pkg.sv ====
// types of the supply supervisor: power state and module state record
package ssv_pkg;
  // ========================================================
  // power state of the chip
  typedef enum logic [0:0] {
    SSV_PWR_OFF,
    SSV_PWR_ON
  } ssv_pwr_type;

  // ========================================================
  // whole state of the supervisor
  typedef struct packed {
    logic [7:0]  s1;        // first sync stage
    logic [7:0]  s2;        // second sync stage
    logic        muv_prev;  // main 90 % detect, last cycle
    logic        xuv_prev;  // xcvr 90 % detect, last cycle
    ssv_pwr_type pwr;       // off or on
    logic [1:0]  mode;      // chip_mode_field
    logic        dsel;      // dissipation_split_select
    logic        rsel;      // reset_level_select
    logic        stb;       // can_standby_ctrl
    logic [2:0]  irq;       // sticky flags
    logic        wr_pend;   // write data phase pending
    logic [7:0]  wr_addr;   // latched write offset
    logic        main_en;   // main regulator on
    logic        xcvr_en;   // transceiver regulator on
    logic        sys_rst;   // system reset
    logic        thr_lo;    // 50 mA threshold chosen
    logic        can_act;   // can active
    logic        can_off;   // can fully off
    logic        rx_out;    // can_receive_out
    logic        tx_drv;    // level to transmitter
    logic        main_st;   // main_reg_status_bit
    logic        xcvr_st;   // xcvr_supply_status_bit
    logic [31:0] hrdata;    // read data
    logic        hready;    // hreadyout
  } ssv_state_type;
endpackage : ssv_pkg

// ==== bench/ssv_far_model.sv ====
// far side model: can protocol controller plus a second node on the bus
`timescale 1ns/10ps
module ssv_far_model
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic can_tx_drive,
  output logic      can_transmit_in,
  output logic      can_bus_rx
);
  logic [3:0] cnt_q;  // pattern counter
  logic       node_q; // level driven by the other node
  // ==========
  // controller keeps sending a pattern; changes only after an edge
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt_q           <= 4'h0;
      node_q          <= 1'b1;
      can_transmit_in <= 1'b1;
    end
    else
    begin
      cnt_q           <= cnt_q + 4'h1;
      node_q          <= (cnt_q != 4'h5);
      can_transmit_in <= cnt_q[1] ^ cnt_q[3];
    end
  // bus is a wired and: dominant low from either node
  assign can_bus_rx = can_tx_drive & node_q;
endmodule : ssv_far_model

// ==== bench/testbench.sv ====
// self-checking bench of the supply supervisor
`timescale 1ns/10ps
`include "ssv_defines.svh"
module testbench;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        hreadyout, hresp;
  logic        poff, pon, muv90, muv70, xuv90, xpin;
  logic        rx, tx, rx_out, tx_drv, can_act, can_off;
  logic        main_en, xcvr_en, sys_rst, ext_lo;
  logic [2:0]  rx_h, tx_h; // pin history for latency compare
  int          compares, miscompares;
  ssv_top u_ssv_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bat_below_poff(poff),
    .bat_above_pon(pon), .main_uv90(muv90), .main_uv70(muv70), .xcvr_uv90(xuv90),
    .xcvr_pin_uv(xpin), .can_bus_rx(rx), .can_transmit_in(tx), .can_receive_out(rx_out),
    .can_tx_drive(tx_drv), .can_active(can_act), .can_off(can_off),
    .main_reg_enable(main_en), .xcvr_reg_enable(xcvr_en), .system_reset(sys_rst),
    .ext_transistor_drive_lo(ext_lo));
  ssv_far_model u_ssv_far_model (.hclk(hclk), .hresetn(hresetn), .can_tx_drive(tx_drv),
    .can_transmit_in(tx), .can_bus_rx(rx));
  // ==========
  // helpers
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    rx_h <= {rx_h[1:0], rx};
    tx_h <= {tx_h[1:0], tx};
  end
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
  endtask : settle
  // single ahb transfer; address phase held until hready is seen high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    k = 0;
    // address phase stands until hready is seen high
    do
    begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    k = 0;
    // data phase stands until hready is seen high again
    do
    begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
    rd = hrdata;
  endtask : ahb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk_word("register", e, rd);
    chk_bit("hresp", 1'b0, hresp);
  endtask : rd_chk
  // ==========
  // scenarios
  task automatic t_off();
    chk_bit("system_reset", 1'b1, sys_rst);
    chk_bit("can_off", 1'b1, can_off);
    ahb(1'b1, `SSV_MODE_OFS, 32'h3);
    rd_chk(`SSV_MODE_OFS, 32'h0);
  endtask : t_off
  task automatic t_power_up();
    pon <= 1'b1;
    settle(2);
    chk_bit("main_reg_enable", 1'b0, main_en);
    settle(4);
    chk_bit("main_reg_enable", 1'b1, main_en);
    rd_chk(`SSV_STAT_OFS, 32'h7);
    rd_chk(`SSV_IRQ_OFS, 32'h1);
    ahb(1'b1, `SSV_IRQ_OFS, 32'h1);
    ahb(1'b1, `SSV_STAT_OFS, 32'h0);
    rd_chk(`SSV_IRQ_OFS, 32'h0);
    rd_chk(8'h20, 32'h0);
  endtask : t_power_up
  task automatic t_main_uv();
    ahb(1'b1, `SSV_CTRL_OFS, 32'h1);
    muv90 <= 1'b1;
    settle(5);
    chk_bit("system_reset", 1'b0, sys_rst);
    rd_chk(`SSV_IRQ_OFS, 32'h2);
    rd_chk(`SSV_STAT_OFS, 32'h6);
    muv70 <= 1'b1;
    settle(5);
    chk_bit("system_reset", 1'b1, sys_rst);
    muv70 <= 1'b0;
    muv90 <= 1'b0;
    ahb(1'b1, `SSV_CTRL_OFS, 32'h0);
    ahb(1'b1, `SSV_IRQ_OFS, 32'h2);
    settle(5);
    chk_bit("system_reset", 1'b0, sys_rst);
    muv90 <= 1'b1;
    settle(5);
    chk_bit("system_reset", 1'b1, sys_rst);
    muv90 <= 1'b0;
    ahb(1'b1, `SSV_IRQ_OFS, 32'h2);
    rd_chk(`SSV_IRQ_OFS, 32'h0);
  endtask : t_main_uv
  task automatic t_dissip();
    ahb(1'b1, `SSV_MODE_OFS, 32'h4);
    settle(4);
    chk_bit("ext_transistor_drive_lo", 1'b1, ext_lo);
    ahb(1'b1, `SSV_MODE_OFS, 32'h0);
    settle(4);
    chk_bit("ext_transistor_drive_lo", 1'b0, ext_lo);
  endtask : t_dissip
  task automatic t_modes();
    logic [1:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = i[2:1];
      ahb(1'b1, `SSV_MODE_OFS, {30'h0, m});
      ahb(1'b1, `SSV_CTRL_OFS, {30'h0, i[0], 1'b0});
      settle(4);
      chk_bit("xcvr_reg_enable", m == 2'h3, xcvr_en);
      chk_bit("can_active", m[1] & !i[0], can_act);
      chk_bit("can_off", !m[1] & !i[0], can_off);
      rd_chk(`SSV_STAT_OFS, 32'h7);
    end
    ahb(1'b1, `SSV_MODE_OFS, 32'h2);
    ahb(1'b1, `SSV_CTRL_OFS, 32'h0);
    xpin <= 1'b1;
    settle(4);
    chk_bit("can_active", 1'b0, can_act);
    xpin <= 1'b0;
    xuv90 <= 1'b1;
    settle(4);
    chk_bit("can_active", 1'b1, can_act);
    rd_chk(`SSV_STAT_OFS, 32'h5);
    rd_chk(`SSV_IRQ_OFS, 32'h4);
    ahb(1'b1, `SSV_IRQ_OFS, 32'h4);
    ahb(1'b1, `SSV_MODE_OFS, 32'h0);
    // status follows the mode one edge after the write lands
    settle(2);
    rd_chk(`SSV_STAT_OFS, 32'h7);
    xuv90 <= 1'b0;
  endtask : t_modes
  task automatic t_can();
    ahb(1'b1, `SSV_MODE_OFS, 32'h3);
    settle(4);
    for (int i = 0; i < 24; i++)
    begin
      @(posedge hclk);
      chk_bit("can_receive_out", rx_h[2], rx_out);
      chk_bit("can_tx_drive", tx_h[2], tx_drv);
    end
    ahb(1'b1, `SSV_CTRL_OFS, 32'h2);
    settle(4);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge hclk);
      chk_bit("can_receive_out", 1'b1, rx_out);
      chk_bit("can_tx_drive", 1'b1, tx_drv);
    end
  endtask : t_can
  task automatic t_power_off();
    pon <= 1'b0;
    poff <= 1'b1;
    settle(5);
    chk_bit("main_reg_enable", 1'b0, main_en);
    chk_bit("xcvr_reg_enable", 1'b0, xcvr_en);
    chk_bit("system_reset", 1'b1, sys_rst);
    rd_chk(`SSV_MODE_OFS, 32'h0);
    poff <= 1'b0;
    pon <= 1'b1;
    settle(5);
    chk_bit("main_reg_enable", 1'b1, main_en);
    rd_chk(`SSV_IRQ_OFS, 32'h1);
  endtask : t_power_off
  // ==========
  // main sequence and hang guard
  initial
  begin
    compares = 0;
    miscompares = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {poff, pon, muv90, muv70, xuv90, xpin} = '0;
    settle(8);
    hresetn <= 1'b1;
    settle(1);
    t_off();
    t_power_up();
    t_main_uv();
    t_dissip();
    t_modes();
    t_can();
    t_power_off();
    stop_test();
  end
  initial
  begin
    settle(20000);
    miscompares++;
    stop_test();
  end
endmodule : testbench
